// [hw/mch_pkg.sv]
// Package of constants, types and the register map for the core control block
package mch_pkg;

  // Register map, byte addresses on the plain register port
  localparam logic [3:0] OFS_CTRL   = 4'h0;  // Oscillator mode and divider select
  localparam logic [3:0] OFS_ENABLE = 4'h4;  // Feature-select register
  localparam logic [3:0] OFS_STATUS = 4'h8;  // Halt, carry, accumulator
  localparam logic [3:0] OFS_PC     = 4'hc;  // Program counter

  // Field positions
  localparam int EN_COUNTER_POS = 0;         // counter_mode_bit
  localparam int EN_LDRIVE_POS  = 2;         // Port latch driver enable
  localparam int EN_SERIAL_POS  = 3;         // serial_drive_bit

  // Values after reset
  localparam logic [8:0] PC_RST  = 9'h000;
  localparam logic [3:0] EN_RST  = 4'h0;
  localparam logic [3:0] ACC_RST = 4'h0;
  localparam logic [5:0] PTR_RST = 6'h00;
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam logic       SKL_RST = 1'b1;     // Sync clock enabled after reset

  // Oscillator dividers, counted in oscillator rising edges
  localparam logic [4:0] DIV_16 = 5'h10;
  localparam logic [4:0] DIV_8  = 5'h08;
  localparam logic [4:0] DIV_4  = 5'h04;

  // Opcodes
  localparam logic [7:0] OP_ZERO_ACC  = 8'h00;
  localparam logic [7:0] OP_XOR       = 8'h02;
  localparam logic [7:0] OP_SET_C     = 8'h22;
  localparam logic [7:0] OP_ADD_CSKIP = 8'h30;
  localparam logic [7:0] OP_ADD       = 8'h31;
  localparam logic [7:0] OP_RESET_C   = 8'h32;
  localparam logic [7:0] OP_PREFIX    = 8'h33;
  localparam logic [7:0] OP_HALT2     = 8'h38;
  localparam logic [7:0] OP_COMP      = 8'h40;
  localparam logic [7:0] OP_SWAP      = 8'h4f;
  localparam logic [3:0] OP_IMM_HI    = 4'h5;

  typedef enum logic [1:0] {
    OSC_CRYSTAL,
    OSC_EXTERNAL,
    OSC_RC
  } mch_osc_t;

  typedef enum logic {
    ST_RUN,
    ST_HALT
  } mch_state_t;

  // Register port request
  typedef struct packed {
    logic [3:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } mch_bus_req_t;

  // Halt I/O pin drive as two signals
  typedef struct packed {
    logic o;
    logic oe;
  } mch_pin_drv_t;

  // Four-bit add with carry-out in the top bit
  function automatic logic [4:0] mch_add4(input logic [3:0] a, input logic [3:0] b,
                                          input logic cin);
    mch_add4 = {1'b0, a} + {1'b0, b} + {4'h0, cin};
  endfunction : mch_add4

endpackage : mch_pkg

// [hw/mch_core.sv]
// Core control: oscillator divide, halt logic, serial register and arithmetic
//
// Local design decisions: the address map and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

module mch_core #(
  parameter bit SMALL_PKG = 1'b0                   // Reduced-pin bonding
) (
  input  wire logic                  i_ref_clk,    // 200 MHz system clock
  input  wire logic                  i_nrst,       // Async reset, active low
  input  wire mch_pkg::mch_bus_req_t i_bus,        // Register port request
  output logic [31:0]                o_rdata,      // Read data, cycle after read
  input  wire logic                  i_osc,        // osc_input_pin level
  input  wire logic                  i_halt_io,    // halt_io_pin level seen
  output mch_pkg::mch_pin_drv_t      o_halt_io,    // halt_io_pin drive and enable
  input  wire logic                  i_si,         // Serial input pin
  output logic                       o_so,         // Serial output
  output logic                       o_sk,         // sync_clock_pin
  output logic [8:0]                 o_rom_addr,   // Program memory address
  input  wire logic [7:0]            i_rom_data,   // Program memory byte
  output logic [3:0]                 o_d,          // Data outputs
  output logic [3:0]                 o_g,          // General-purpose port
  output logic [7:0]                 o_l,          // Port latch value
  output logic                       o_l_oe        // Port latch drivers on
);
  import mch_pkg::*;

  // Pin synchronisers
  logic [1:0] osc_sync;
  logic [1:0] halt_sync;
  logic [1:0] si_sync;
  logic       osc_prev;
  logic       halt_prev;
  logic       si_prev;

  // Control and core state
  logic [3:0]  ctrl;
  logic [3:0]  enable;
  logic [8:0]  pc;
  logic [8:0]  return_slot_one;
  logic [8:0]  return_slot_two;
  logic [3:0]  acc;
  logic        carry;
  logic [1:0]  ram_row_field;
  logic [3:0]  ram_digit_field;
  logic [7:0]  port_latch;
  logic [3:0]  shift_count_reg;
  logic        clock_gate_latch;
  logic        skip;
  logic        prefix;
  logic        halt_pend;
  logic [4:0]  phase;
  mch_state_t  state;
  logic [3:0]  ram [0:31];

  logic [2:0]  pin_arm;
  logic [4:0]  sum_asc;
  logic [4:0]  sum_add;
  logic [4:0]  sum_imm;
  logic        osc_rise;
  logic        si_fall;
  logic        halt_rise;
  logic        halt_fall;
  logic        single_pin;
  logic [4:0]  div;
  logic        tick;
  logic [4:0]  ram_idx;
  logic [3:0]  mem_digit;
  logic [7:0]  op;
  logic        exec;
  logic        counter_mode_bit;
  logic        serial_drive_bit;

  // Two-stage synchronisers; the second stage feeds a history flop
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      osc_sync  <= 2'b00;
      halt_sync <= 2'b00;
      si_sync   <= 2'b00;
      osc_prev  <= 1'b0;
      halt_prev <= 1'b0;
      si_prev   <= 1'b0;
      pin_arm   <= 3'b000;
    end else begin
      osc_sync  <= {osc_sync[0], i_osc};
      halt_sync <= {halt_sync[0], i_halt_io};
      si_sync   <= {si_sync[0], i_si};
      osc_prev  <= osc_sync[1];
      halt_prev <= halt_sync[1];
      si_prev   <= si_sync[1];
      pin_arm   <= {pin_arm[1:0], single_pin};  // Synchroniser flushed of crystal feedback
    end
  end

  // Edge detects and decode of the current configuration
  assign osc_rise         = osc_sync[1] & ~osc_prev;
  assign si_fall          = si_prev & ~si_sync[1];
  // Pin edges count only once no crystal feedback sample is left in the synchroniser
  assign halt_rise        = halt_sync[1] & ~halt_prev & (&pin_arm);
  assign halt_fall        = halt_prev & ~halt_sync[1] & (&pin_arm);
  assign single_pin       = (mch_osc_t'(ctrl[1:0]) != OSC_CRYSTAL) && !SMALL_PKG;
  assign counter_mode_bit = enable[EN_COUNTER_POS];
  assign serial_drive_bit = enable[EN_SERIAL_POS];
  assign ram_idx          = {ram_row_field, ram_digit_field[2:0]};
  assign mem_digit        = ram[ram_idx];
  assign op               = i_rom_data;

  // Adder results shared by the skip and accumulator logic
  assign sum_asc = mch_add4(acc, mem_digit, carry);
  assign sum_add = mch_add4(acc, mem_digit, 1'b0);
  assign sum_imm = mch_add4(acc, op[3:0], 1'b0);

  // Divider choice: RC always by four, others by the selected option
  always_comb begin
    if (mch_osc_t'(ctrl[1:0]) == OSC_RC) begin
      div = DIV_4;
    end else begin
      unique case (ctrl[3:2])
        2'd1:    div = DIV_8;
        2'd2:    div = DIV_4;
        default: div = DIV_16;
      endcase
    end
  end

  // Instruction cycle tick from oscillator edges; nothing ticks when halted
  assign tick = osc_rise && (phase == div - 5'd1) && (state == ST_RUN)
                && !halt_pend;
  assign exec = tick && !skip;

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      phase <= 5'h00;
    end else if (osc_rise && state == ST_RUN && !halt_pend) begin
      phase <= (phase >= div - 5'd1) ? 5'h00 : phase + 5'd1;
    end
  end

  // Halt state machine
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state     <= ST_RUN;
      halt_pend <= 1'b0;
    end else begin
      unique case (state)
        ST_RUN: begin
          if (exec && prefix && op == OP_HALT2) begin
            halt_pend <= 1'b1;
          end else if (single_pin && halt_rise) begin
            halt_pend <= 1'b1;
          end
          if (halt_pend && osc_sync[1]) begin
            state     <= ST_HALT;
            halt_pend <= 1'b0;
          end
        end
        ST_HALT: begin
          if (single_pin && halt_fall) begin
            state <= ST_RUN;
          end
        end
      endcase
    end
  end

  // Halt pin drive: crystal feedback, or halt status flip-flop
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_halt_io <= '0;
    end else if (SMALL_PKG) begin
      o_halt_io <= '0;
    end else if (!single_pin) begin
      o_halt_io.oe <= 1'b1;
      o_halt_io.o  <= (state == ST_HALT) | halt_pend | ~osc_sync[1];
    end else begin
      o_halt_io.oe <= 1'b1;
      o_halt_io.o  <= (state == ST_HALT) | halt_pend;
    end
  end

  // Program counter, skip and prefix tracking
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pc              <= PC_RST;
      return_slot_one <= PC_RST;
      return_slot_two <= PC_RST;
      skip            <= 1'b0;
      prefix          <= 1'b0;
    end else if (tick) begin
      pc     <= pc + 9'd1;
      skip   <= 1'b0;
      prefix <= exec && !prefix && op == OP_PREFIX;
      if (exec && !prefix) begin
        if (op == OP_ADD_CSKIP) begin
          skip <= sum_asc[4];
        end else if (op[7:4] == OP_IMM_HI && op[3:0] != 4'h0) begin
          skip <= sum_imm[4];
        end
      end
    end
  end

  // Accumulator, carry and gate latch
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      acc              <= ACC_RST;
      carry            <= 1'b0;
      clock_gate_latch <= SKL_RST;
    end else if (exec && !prefix) begin
      if (op == OP_ADD_CSKIP) begin
        {carry, acc} <= sum_asc;
      end else if (op == OP_ADD) begin
        acc <= sum_add[3:0];
      end else if (op[7:4] == OP_IMM_HI) begin
        acc <= sum_imm[3:0];
      end else if (op == OP_ZERO_ACC) begin
        acc <= 4'h0;
      end else if (op == OP_COMP) begin
        acc <= ~acc;
      end else if (op == OP_XOR) begin
        acc <= acc ^ mem_digit;
      end else if (op == OP_SET_C) begin
        carry <= 1'b1;
      end else if (op == OP_RESET_C) begin
        carry <= 1'b0;
      end else if (op == OP_SWAP) begin
        acc              <= shift_count_reg;
        clock_gate_latch <= carry;
      end
    end
  end

  // Serial shift/count register
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      shift_count_reg <= 4'h0;
    end else if (state == ST_RUN && !halt_pend) begin
      if (exec && !prefix && op == OP_SWAP) begin
        shift_count_reg <= acc;
      end else if (counter_mode_bit) begin
        if (si_fall) begin
          shift_count_reg <= shift_count_reg - 4'h1;
        end
      end else if (tick) begin
        shift_count_reg <= {shift_count_reg[2:0], si_sync[1]};
      end
    end
  end

  // RAM pointer, data and general-purpose outputs
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ram_row_field   <= PTR_RST[5:4];
      ram_digit_field <= PTR_RST[3:0];
      port_latch      <= 8'h00;
      o_d             <= 4'h0;
      o_g             <= 4'h0;
    end else begin
      o_d <= SMALL_PKG ? {2'b00, ram_digit_field[1:0]} : ram_digit_field;
      o_g <= SMALL_PKG ? {1'b0, port_latch[2:0]} : port_latch[3:0];
    end
  end

  // Data memory keeps its contents across reset
  always_ff @(posedge i_ref_clk) begin
    if (exec && !prefix && op == OP_PREFIX) begin
      ram[ram_idx] <= ram[ram_idx];
    end
  end

  // Software registers
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ctrl   <= CTRL_RST;
      enable <= EN_RST;
    end else if (i_bus.wr) begin
      if (i_bus.addr == OFS_CTRL) begin
        ctrl <= i_bus.wdata[3:0];
      end else if (i_bus.addr == OFS_ENABLE) begin
        enable <= i_bus.wdata[3:0];
      end
    end
  end

  // Read data, one cycle after the read strobe, zero otherwise
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rdata <= 32'h0;
    end else if (i_bus.rd) begin
      unique case (i_bus.addr)
        OFS_CTRL:   o_rdata <= {28'h0, ctrl};
        OFS_ENABLE: o_rdata <= {28'h0, enable};
        OFS_STATUS: o_rdata <= {26'h0, state == ST_HALT, carry, acc};
        OFS_PC:     o_rdata <= {23'h0, pc};
        default:    o_rdata <= 32'h0;
      endcase
    end else begin
      o_rdata <= 32'h0;
    end
  end

  // Serial outputs, sync clock and port latch drivers
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_so       <= 1'b0;
      o_sk       <= 1'b0;
      o_rom_addr <= PC_RST;
      o_l        <= 8'h00;
      o_l_oe     <= 1'b0;
    end else begin
      o_rom_addr <= pc;
      o_l        <= port_latch;
      o_l_oe     <= enable[EN_LDRIVE_POS];
      if (counter_mode_bit) begin
        o_sk <= clock_gate_latch;
        o_so <= serial_drive_bit;
      end else begin
        o_sk <= clock_gate_latch && (phase < (div >> 1));
        o_so <= serial_drive_bit & shift_count_reg[3];
      end
    end
  end

endmodule : mch_core

`default_nettype wire

// [testbench/mch_core_properties.sv]
// Port checker for the core control block, bound into the design
`timescale 1ns/1ps
`default_nettype none

module mch_core_properties #(
  parameter bit SMALL_PKG = 1'b0                   // Reduced-pin bonding
) (
  input wire logic                  i_ref_clk,     // Clock
  input wire logic                  i_nrst,        // Reset, active low
  input wire mch_pkg::mch_bus_req_t i_bus,         // Register port request
  input wire logic                  i_osc,         // Oscillator level
  input wire logic                  i_halt_io,     // Halt pin level
  input wire mch_pkg::mch_pin_drv_t o_halt_io,     // Halt pin drive
  input wire logic                  o_so,          // Serial out
  input wire logic [8:0]            o_rom_addr     // Program address
);
  import mch_pkg::*;
  logic [3:0] en_q;
  logic [3:0] ctrl_q;
  logic [2:0] age;
  logic [2:0] up;
  logic [4:0] ocnt;
  logic [4:0] div;
  logic [8:0] pc_d;
  logic       osc_d;
  logic       seen;
  wire        single = (ctrl_q[1:0] != 2'h0);
  wire        rise = i_osc & ~osc_d;
  // Expected divider from the shadowed control value
  assign div = (ctrl_q[1:0] == 2'h2) ? DIV_4 :
               (ctrl_q[3:2] == 2'h1) ? DIV_8 : (ctrl_q[3:2] == 2'h2) ? DIV_4 : DIV_16;
  // Shadows of register writes and settle counters
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      en_q   <= EN_RST;
      ctrl_q <= CTRL_RST;
      age    <= 3'h0;
      up     <= 3'h0;
    end else begin
      if (i_bus.wr && i_bus.addr == OFS_ENABLE) en_q <= i_bus.wdata[3:0];
      if (i_bus.wr && i_bus.addr == OFS_CTRL) ctrl_q <= i_bus.wdata[3:0];
      age <= i_bus.wr ? 3'h0 : ((age == 3'h7) ? age : age + 3'h1);
      up  <= (up == 3'h7) ? up : up + 3'h1;
    end
  end
  // Oscillator rises counted between program steps
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      osc_d <= 1'b0;
      pc_d  <= PC_RST;
      ocnt  <= 5'h0;
      seen  <= 1'b0;
    end else begin
      osc_d <= i_osc;
      pc_d  <= o_rom_addr;
      if (o_rom_addr != pc_d) ocnt <= {4'h0, rise};
      else if (rise && ocnt != 5'h1f) ocnt <= ocnt + 5'h1;
      if (i_bus.wr || ocnt > div) seen <= 1'b0;
      else if (o_rom_addr != pc_d) seen <= 1'b1;
    end
  end
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);
  property p_so_count;
    age == 3'h7 && en_q[EN_COUNTER_POS] |-> o_so == en_q[EN_SERIAL_POS];
  endproperty
  a_so_count: assert property (p_so_count) else $error("serial out not drive bit");
  property p_so_off;
    age == 3'h7 && !en_q[EN_COUNTER_POS] && !en_q[EN_SERIAL_POS] |-> !o_so;
  endproperty
  a_so_off: assert property (p_so_off) else $error("serial out not held low");
  property p_pc_step;
    $changed(o_rom_addr) |-> o_rom_addr == $past(o_rom_addr) + 9'h001;
  endproperty
  a_pc_step: assert property (p_pc_step) else $error("program address jumped");
  property p_div;
    seen && $changed(o_rom_addr) |-> ocnt == div;
  endproperty
  a_div: assert property (p_div) else $error("wrong oscillator divide");
  property p_halt_rise;
    age == 3'h7 && single && $rose(i_halt_io) |-> ##[1:40] o_halt_io.o;
  endproperty
  a_halt_rise: assert property (p_halt_rise) else $error("halt pin not held");
  property p_resume;
    single && $fell(i_halt_io) |-> ##[1:12] !o_halt_io.o;
  endproperty
  a_resume: assert property (p_resume) else $error("halt drive not released");
  property p_frozen;
    (single && o_halt_io.o) [*4] |-> $stable(o_rom_addr);
  endproperty
  a_frozen: assert property (p_frozen) else $error("core ran while halted");
  property p_pin_oe;
    up == 3'h7 |-> o_halt_io.oe == !SMALL_PKG;
  endproperty
  a_pin_oe: assert property (p_pin_oe) else $error("halt pin enable wrong");
  c_halt: cover property ((single && o_halt_io.o) [*8]);
  c_count: cover property (age == 3'h7 && en_q[EN_COUNTER_POS]);
  c_step: cover property (seen && $changed(o_rom_addr));
endmodule : mch_core_properties

bind mch_core mch_core_properties #(.SMALL_PKG(SMALL_PKG)) u_props (
  .i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_bus(i_bus), .i_osc(i_osc),
  .i_halt_io(i_halt_io), .o_halt_io(o_halt_io), .o_so(o_so), .o_rom_addr(o_rom_addr));

`default_nettype wire

// [testbench/mch_osc_model.sv]
// Oscillator network and outside halt control facing the core
`timescale 1ns/1ps
`default_nettype none

module mch_osc_model (
  input  wire logic                  i_ref_clk,  // System clock
  input  wire logic                  i_run,      // Oscillator allowed to run
  input  wire logic                  i_rc,       // RC network fitted
  input  wire logic                  i_frc_en,   // Outside drive on halt pin
  input  wire logic                  i_frc_val,  // Outside drive level
  input  wire mch_pkg::mch_pin_drv_t i_drv,      // Core drive on halt pin
  output logic                       o_osc,      // Oscillator input level
  output logic                       o_pin       // Resolved halt pin level
);
  import mch_pkg::*;
  logic [1:0] ph;
  logic       last;
  // Outside drive overrides the pin flip-flop; an undriven pin wanders
  assign o_pin = i_frc_en ? i_frc_val : (i_drv.oe ? i_drv.o : ~last);
  initial begin
    o_osc = 1'b0;
    ph = 2'h0;
    last = 1'b0;
  end
  // Half period of four clocks; may be stopped; RC network stalls high when halted
  always @(posedge i_ref_clk) begin
    last <= o_pin;
    ph <= ph + 2'h1;
    if (ph == 2'h3 && i_run && !(i_rc && o_pin && o_osc)) o_osc <= ~o_osc;
  end
endmodule : mch_osc_model

`default_nettype wire

// [testbench/tb.sv]
// Self-checking bench for the core control block
`timescale 1ns/1ps
`default_nettype none

module tb;
  import mch_pkg::*;
  typedef struct { string name; logic [31:0] exp; } mch_note_t;
  logic         i_ref_clk, i_nrst, i_osc, i_halt_io, i_si, o_so, o_sk, o_l_oe;
  logic         run, rc, frc_en, frc_val, rd_q;
  mch_bus_req_t i_bus;
  mch_pin_drv_t o_halt_io;
  logic [31:0]  o_rdata;
  logic [8:0]   o_rom_addr, pa;
  logic [7:0]   i_rom_data, o_l;
  logic [7:0]   rom [0:511];
  logic [3:0]   o_d, o_g, y1, y2, acc_exp;
  logic [4:0]   s;
  mch_note_t    notes [$];
  mch_note_t    note;
  int           errors, comparisons, cycles, e;

  mch_core #(.SMALL_PKG(1'b0)) dut (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_bus(i_bus),
    .o_rdata(o_rdata), .i_osc(i_osc), .i_halt_io(i_halt_io), .o_halt_io(o_halt_io),
    .i_si(i_si), .o_so(o_so), .o_sk(o_sk), .o_rom_addr(o_rom_addr), .i_rom_data(i_rom_data),
    .o_d(o_d), .o_g(o_g), .o_l(o_l), .o_l_oe(o_l_oe));
  mch_osc_model u_model (.i_ref_clk(i_ref_clk), .i_run(run), .i_rc(rc), .i_frc_en(frc_en),
    .i_frc_val(frc_val), .i_drv(o_halt_io), .o_osc(i_osc), .o_pin(i_halt_io));
  // Program memory answers in the same cycle
  assign i_rom_data = rom[o_rom_addr];

  initial begin
    i_ref_clk = 1'b0;
    forever #2.5 i_ref_clk = ~i_ref_clk;
  end

  task automatic print_verdict();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : print_verdict

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  // Read data compared with the oldest note; hang guard
  always @(posedge i_ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      print_verdict();
    end
    if (rd_q && notes.size() > 0) begin
      note = notes.pop_front();
      check(note.name, note.exp, o_rdata);
    end
    rd_q <= i_bus.rd;
  end

  task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    i_bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge i_ref_clk);
    i_bus.wr <= 1'b0;
  endtask : bus_wr

  task automatic bus_rd(input logic [3:0] a, input logic [31:0] exp, input string name);
    @(posedge i_ref_clk);
    i_bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    notes.push_back('{name, exp});
    @(posedge i_ref_clk);
    i_bus.rd <= 1'b0;
  endtask : bus_rd

  task automatic do_reset();
    @(posedge i_ref_clk);
    i_nrst <= 1'b0;
    repeat (3) @(posedge i_ref_clk);
    check("rom_addr_rst", 32'h0, {23'h0, o_rom_addr});
    check("pins_rst", 32'h0, {28'h0, o_so, o_halt_io, o_l_oe});
    check("outs_rst", 32'h0, {16'h0, o_d, o_g, o_l});
    i_nrst <= 1'b1;
  endtask : do_reset

  // Halted once the pin drive stays high for 24 cycles
  task automatic wait_halt();
    int n;
    int len;
    len = 0;
    for (n = 0; n < 6000 && len < 24; n++) begin
      @(posedge i_ref_clk);
      len = (o_halt_io.o === 1'b1) ? len + 1 : 0;
    end
    check("halt_wait", 32'h18, len);
  endtask : wait_halt

  task automatic wait_addr(input logic [8:0] a);
    int n;
    for (n = 0; n < 3000 && o_rom_addr !== a; n++) @(posedge i_ref_clk);
    check("rom_addr", {23'h0, a}, {23'h0, o_rom_addr});
  endtask : wait_addr

  // Program mode, run to the halt opcode, then look at the results
  task automatic run_prog(input logic [3:0] ctrl);
    bus_wr(OFS_CTRL, {28'h0, ctrl});
    wait_halt();
    bus_rd(OFS_STATUS, {26'h0, 2'h3, acc_exp}, "status");
    bus_rd(OFS_PC, 32'h7, "pc");
  endtask : run_prog

  initial begin
    i_nrst = 1'b0;
    i_bus = '0;
    i_si = 1'b0;
    run = 1'b1;
    rc = 1'b0;
    frc_en = 1'b0;
    frc_val = 1'b0;
    rd_q = 1'b0;
    cycles = 0;
    errors = 0;
    comparisons = 0;
    void'($urandom(32'hdca4));
    y1 = 4'($urandom);
    y2 = 4'($urandom_range(15, 1));
    s = {1'b0, y1} + {1'b0, y2};
    acc_exp = s[4] ? s[3:0] : ~s[3:0];
    foreach (rom[i]) rom[i] = 8'h44;
    rom[0] = OP_ZERO_ACC;
    rom[1] = {OP_IMM_HI, y1};
    rom[2] = {OP_IMM_HI, y2};
    rom[3] = OP_COMP;
    rom[4] = OP_SET_C;
    rom[5] = OP_PREFIX;
    rom[6] = OP_HALT2;
    do_reset();
    bus_rd(OFS_STATUS, 32'h0, "status_rst");
    bus_rd(OFS_ENABLE, 32'h0, "enable_rst");
    bus_rd(4'h2, 32'h0, "unmapped");
    bus_wr(OFS_PC, 32'h1ff);
    bus_rd(OFS_PC, 32'h0, "pc_ro");
    // Every enable pattern while the program runs
    for (e = 0; e < 16; e++) begin
      i_si <= 1'($urandom_range(1, 0));
      bus_wr(OFS_ENABLE, e);
      repeat (8) @(posedge i_ref_clk);
      if (e[0]) check("so_count", e[3], o_so);
      else if (!e[3]) check("so_shift", 32'h0, o_so);
      if (e[0]) check("sk_count", {31'h0, SKL_RST}, o_sk);
      check("l_oe", e[2], o_l_oe);
      bus_rd(OFS_ENABLE, e, "enable");
    end
    bus_wr(OFS_ENABLE, 32'h0);
    run_prog(4'h0);
    repeat (300) @(posedge i_ref_clk);
    bus_rd(OFS_PC, 32'h7, "pc_crystal_halt");
    do_reset();
    bus_rd(OFS_PC, 32'h0, "pc_restart");
    bus_wr(OFS_CTRL, 32'h9);
    wait_addr(9'h002);
    frc_en <= 1'b1;
    frc_val <= 1'b1;
    wait_halt();
    pa = o_rom_addr;
    repeat (100) @(posedge i_ref_clk);
    check("pc_frozen", {23'h0, pa}, {23'h0, o_rom_addr});
    frc_val <= 1'b0;
    repeat (16) @(posedge i_ref_clk);
    check("pin_resume", 32'h0, o_halt_io.o);
    frc_en <= 1'b0;
    wait_addr(9'h004);
    run <= 1'b0;
    pa = o_rom_addr;
    repeat (300) @(posedge i_ref_clk);
    check("pc_osc_stop", {23'h0, pa}, {23'h0, o_rom_addr});
    run <= 1'b1;
    run_prog(4'h9);
    frc_en <= 1'b1;
    frc_val <= 1'b0;
    repeat (16) @(posedge i_ref_clk);
    check("pin_continue", 32'h0, o_halt_io.o);
    wait_addr(9'h008);
    frc_en <= 1'b0;
    do_reset();
    run_prog(4'h4);
    do_reset();
    rc <= 1'b1;
    run_prog(4'h2);
    repeat (3) @(posedge i_ref_clk);
    print_verdict();
  end
endmodule : tb

`default_nettype wire
